// ---- rtl/frt_regs.vh ----
// Register map, field layout and constants of the free running timer counter
`ifndef FRT_REGS_VH
`define FRT_REGS_VH

// Byte addresses of the word registers
`define FRT_ADDR_COUNT_HI 12'h000
`define FRT_ADDR_COUNT_LO 12'h004
`define FRT_ADDR_SHADOW_HI 12'h008
`define FRT_ADDR_SHADOW_LO 12'h00C
`define FRT_ADDR_STATUS 12'h010
`define FRT_ADDR_CTRL_ONE 12'h014
`define FRT_ADDR_CTRL_TWO 12'h018

// Field positions
`define FRT_CTL1_IRQ_EN 0
`define FRT_CTL2_CLKSEL_LO 0
`define FRT_CTL2_CLKSEL_HI 1
`define FRT_CTL2_EDGE 2
`define FRT_STAT_ROLLOVER 7

// Values
`define FRT_COUNT_RESET 16'hFFFC
`define FRT_COUNT_MAX 16'hFFFF
`define FRT_CLK_DIV4 2'h0
`define FRT_CLK_DIV2 2'h1
`define FRT_CLK_DIV8 2'h2
`define FRT_CLK_EXT 2'h3
`define FRT_PRESC_W 3
`define FRT_PRESC_ONE 3'h1
`define FRT_MASK_DIV2 3'h1
`define FRT_MASK_DIV4 3'h3
`define FRT_MASK_DIV8 3'h7

`endif

// ---- rtl/frt_timer.v ----
// Free running 16-bit timer counter with APB register access
`timescale 1ns/10ps
`include "frt_regs.vh"

module frt_timer (
   // Clock and reset
   input wire clk_in,
   input wire rstn_in,
   // APB slave
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [11:0] paddr_in,
   input wire [31:0] pwdata_in,
   output wire [31:0] prdata_out,
   output wire pready_out,
   output wire pslverr_out,
   // System
   input wire halt_in,
   input wire cpu_irq_mask_in,
   input wire ext_clock_pin_in,
   input wire ext_clock_bonded_in,
   // Interrupt request
   output wire irq_out
);

   ////////////////////////////////////////////////////////////////////////////
   reg [15:0] count_ff;
   reg [15:0] nxt_count;
   reg [7:0] lo_buf_ff;
   reg [7:0] nxt_lo_buf;
   reg buf_held_ff;
   reg nxt_buf_held;
   reg rollover_flag_ff;
   reg nxt_rollover_flag;
   reg clear_armed_ff;
   reg nxt_clear_armed;
   reg [`FRT_PRESC_W-1:0] presc_ff;
   reg ext_sync_ff;
   reg ext_pin_ff;
   reg ext_prev_ff;
   reg rollover_irq_enable_ff;
   reg [2:0] timer_control_two_ff;
   reg [31:0] rdata_ff;
   reg [31:0] nxt_rdata;
   reg wait_ff;
   wire acc_first;
   wire done;
   reg tick;
   reg [`FRT_PRESC_W-1:0] presc_mask;
   wire [1:0] clock_select;
   wire ext_clock_edge_select;
   wire ext_level;
   wire ext_edge;
   wire acc;
   wire wr;
   wire rd;
   wire mapped;

   assign clock_select = timer_control_two_ff[`FRT_CTL2_CLKSEL_HI:`FRT_CTL2_CLKSEL_LO];
   assign ext_clock_edge_select = timer_control_two_ff[`FRT_CTL2_EDGE];

   // One wait state: read data is registered in the first access cycle, so it
   // stands at the completing edge; writes land at the completing edge
   assign acc = psel_in & penable_in;
   assign acc_first = acc & ~wait_ff;
   assign done = acc & wait_ff;
   assign wr = done & pwrite_in;
   assign rd = acc_first & ~pwrite_in;
   assign pready_out = wait_ff;
   assign mapped = (paddr_in == `FRT_ADDR_COUNT_HI) | (paddr_in == `FRT_ADDR_COUNT_LO) |
                   (paddr_in == `FRT_ADDR_SHADOW_HI) | (paddr_in == `FRT_ADDR_SHADOW_LO) |
                   (paddr_in == `FRT_ADDR_STATUS) | (paddr_in == `FRT_ADDR_CTRL_ONE) |
                   (paddr_in == `FRT_ADDR_CTRL_TWO);
   assign pslverr_out = acc & ~mapped;
   assign prdata_out = rdata_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Unbonded pin reads as high, so it never produces edges
   assign ext_level = ext_clock_bonded_in ? ext_clock_pin_in : 1'b1;

   // Two-stage synchroniser, then edge detect on the clean stage
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ext_sync_ff <= 1'b1;
         ext_pin_ff <= 1'b1;
         ext_prev_ff <= 1'b1;
      end else begin
         ext_sync_ff <= ext_level;
         ext_pin_ff <= ext_sync_ff;
         ext_prev_ff <= ext_pin_ff;
      end
   end

   // Rising when select set, falling otherwise; needs slow pin
   assign ext_edge = ext_clock_edge_select ? (ext_pin_ff & ~ext_prev_ff) : (~ext_pin_ff & ext_prev_ff);

   ////////////////////////////////////////////////////////////////////////////
   // Divider mask per clock selection
   always @* begin
      case (clock_select)
         `FRT_CLK_DIV4: presc_mask = `FRT_MASK_DIV4;
         `FRT_CLK_DIV2: presc_mask = `FRT_MASK_DIV2;
         `FRT_CLK_DIV8: presc_mask = `FRT_MASK_DIV8;
         default: presc_mask = {`FRT_PRESC_W{1'b0}};
      endcase
   end

   // Count enable: prescaler terminal count or external edge; halt freezes both
   always @* begin
      if (halt_in) begin
         tick = 1'b0;
      end else if (clock_select == `FRT_CLK_EXT) begin
         tick = ext_edge;
      end else begin
         tick = ((presc_ff & presc_mask) == presc_mask);
      end
   end

   // Prescaler runs from reset, holding only while halted, so two instances stay in step
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         presc_ff <= {`FRT_PRESC_W{1'b0}};
      end else if (!halt_in) begin
         presc_ff <= presc_ff + `FRT_PRESC_ONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter, read buffer, flag and clear sequence
   always @* begin
      nxt_count = count_ff;
      nxt_lo_buf = lo_buf_ff;
      nxt_buf_held = buf_held_ff;
      nxt_rollover_flag = rollover_flag_ff;
      nxt_clear_armed = clear_armed_ff;
      nxt_rdata = 32'h0;
      if (tick) begin
         nxt_count = count_ff + 16'h0001;
      end
      if (wr && ((paddr_in == `FRT_ADDR_COUNT_LO) || (paddr_in == `FRT_ADDR_SHADOW_LO))) begin
         nxt_count = `FRT_COUNT_RESET;
      end
      // Status read arms clear only when the flag is seen set
      if (rd && (paddr_in == `FRT_ADDR_STATUS)) begin
         nxt_clear_armed = rollover_flag_ff;
      end
      if ((rd || wr) && (paddr_in == `FRT_ADDR_COUNT_LO) && clear_armed_ff) begin
         nxt_rollover_flag = 1'b0;
         nxt_clear_armed = 1'b0;
      end
      // Set wins over a coincident clear
      if (tick && (count_ff == `FRT_COUNT_MAX)) begin
         nxt_rollover_flag = 1'b1;
      end
      if (rd) begin
         case (paddr_in)
            `FRT_ADDR_COUNT_HI, `FRT_ADDR_SHADOW_HI: begin
               nxt_rdata = {24'h0, count_ff[15:8]};
               if (!buf_held_ff) begin
                  nxt_lo_buf = count_ff[7:0];
                  nxt_buf_held = 1'b1;
               end
            end
            `FRT_ADDR_COUNT_LO, `FRT_ADDR_SHADOW_LO: begin
               nxt_rdata = {24'h0, buf_held_ff ? lo_buf_ff : count_ff[7:0]};
               nxt_buf_held = 1'b0;
            end
            `FRT_ADDR_STATUS: nxt_rdata = {24'h0, rollover_flag_ff, 7'h0};
            `FRT_ADDR_CTRL_ONE: nxt_rdata = {31'h0, rollover_irq_enable_ff};
            `FRT_ADDR_CTRL_TWO: nxt_rdata = {29'h0, timer_control_two_ff};
            default: nxt_rdata = 32'h0;
         endcase
      end
   end

   // Data register loaded in the first access cycle; stands while pready is high
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wait_ff <= 1'b0;
         count_ff <= `FRT_COUNT_RESET;
         lo_buf_ff <= 8'h00;
         buf_held_ff <= 1'b0;
         rollover_flag_ff <= 1'b0;
         clear_armed_ff <= 1'b0;
         rdata_ff <= 32'h0;
      end else begin
         wait_ff <= acc_first;
         count_ff <= nxt_count;
         lo_buf_ff <= nxt_lo_buf;
         buf_held_ff <= nxt_buf_held;
         rollover_flag_ff <= nxt_rollover_flag;
         clear_armed_ff <= nxt_clear_armed;
         rdata_ff <= nxt_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rollover_irq_enable_ff <= 1'b0;
         timer_control_two_ff <= 3'h0;
      end else if (wr && (paddr_in == `FRT_ADDR_CTRL_ONE)) begin
         rollover_irq_enable_ff <= pwdata_in[`FRT_CTL1_IRQ_EN];
      end else if (wr && (paddr_in == `FRT_ADDR_CTRL_TWO)) begin
         timer_control_two_ff <= pwdata_in[2:0];
      end
   end

   // Flag stays pending while masked
   assign irq_out = rollover_flag_ff & rollover_irq_enable_ff & ~cpu_irq_mask_in;

endmodule // frt_timer

// ---- testbench/frt_ext_clk_src.sv ----
// External clock source model driving the timer clock pin
`timescale 1ns/10ps
module frt_ext_clk_src #(parameter int HALF = 4) (
   // Clock and control
   input wire logic clk_in,
   input wire logic run_in,
   // Pin
   output logic pin_out
);
   int cnt = 0;
   initial pin_out = 1'b0;
   // Like edges 2*HALF clocks apart; holds its level when stopped
   always @(posedge clk_in) begin
      if (run_in) begin
         cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
         if (cnt == HALF - 1) pin_out <= ~pin_out;
      end
   end
endmodule // frt_ext_clk_src

// ---- testbench/frt_timer_checker.sv ----
// Port level assertions of the free running timer
`timescale 1ns/10ps
module frt_timer_checker (
   input wire clk_in,
   input wire rstn_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [11:0] paddr_in,
   input wire [31:0] prdata_out,
   input wire pready_out,
   input wire pslverr_out,
   input wire halt_in,
   input wire cpu_irq_mask_in,
   input wire irq_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   wire acc = psel_in && penable_in;
   wire done = acc && pready_out;
   wire rd = acc && !pwrite_in;
   sequence s_hi_rd; halt_in && done && !pwrite_in && paddr_in == 12'h000; endsequence
   sequence s_lo_rd; halt_in && done && !pwrite_in && paddr_in == 12'h004; endsequence
   sequence s_lo_wr; halt_in && done && pwrite_in && paddr_in == 12'h004; endsequence
   //////////////////////////////
   chk_ready_wait: assert property (acc && !pready_out |=> pready_out) else $error("no ready after wait");
   chk_err_unmapped: assert property (acc && paddr_in > 12'h018 |-> pslverr_out) else $error("no slave error");
   chk_rd_zero: assert property (!rd || pslverr_out |=> prdata_out == 32'h0) else $error("stale read data");
   chk_mask_blocks: assert property (cpu_irq_mask_in |-> !irq_out) else $error("irq while masked");
   chk_irq_pending: assert property (irq_out && !(acc && (paddr_in == 12'h004 || paddr_in == 12'h014))
      |=> irq_out || cpu_irq_mask_in) else $error("irq dropped");
   chk_shadow_keep: assert property (irq_out && acc && paddr_in == 12'h00C
      |=> irq_out || cpu_irq_mask_in) else $error("shadow cleared flag");
   chk_halt_frozen: assert property (s_hi_rd ##4 s_hi_rd |-> prdata_out == $past(prdata_out, 4))
      else $error("count moved in halt");
   chk_wr_reload: assert property (s_lo_wr ##4 s_lo_rd |-> prdata_out == 32'hFC) else $error("no reload");
endmodule // frt_timer_checker

bind frt_timer frt_timer_checker i_frt_timer_checker (.clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in,
   .paddr_in, .prdata_out, .pready_out, .pslverr_out, .halt_in, .cpu_irq_mask_in, .irq_out);

// ---- testbench/tb_top.sv ----
// Self-checking bench of the free running timer
`timescale 1ns/10ps
module tb_top;
   logic clk_in = 0, rstn_in = 0, psel = 0, pen = 0, pwr = 0, halt = 1, mask = 1, bond = 1, run = 0;
   logic [11:0] pa = 0;
   logic [31:0] pw = 0, rd, v;
   logic [15:0] e;
   wire [31:0] prd;
   wire rdy, err, irq, xpin;
   int miscompares = 0, num_checks = 0;
   int sel[6] = '{0, 1, 2, 3, 7, 3}, dlt[6] = '{16, 32, 8, 8, 8, 0};
   initial forever #50 clk_in = ~clk_in;
   frt_timer i_frt_timer (.clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pw), .prdata_out(prd), .pready_out(rdy), .pslverr_out(err),
      .halt_in(halt), .cpu_irq_mask_in(mask), .ext_clock_pin_in(xpin), .ext_clock_bonded_in(bond),
      .irq_out(irq));
   frt_ext_clk_src i_frt_ext_clk_src (.clk_in(clk_in), .run_in(run), .pin_out(xpin));
   //////////////////////////////
   task complete_run;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] g, x);
      num_checks++;
      if (g !== x) begin
         miscompares++;
         $display("mismatch at %0t got %h exp %h", $time, g, x);
      end
   endtask
   // Range compare, for counts whose prescaler phase is unknown
   task rng(input logic [31:0] g, lo, hi);
      num_checks++;
      if (^g === 1'bx || g < lo || g > hi) begin
         miscompares++;
         $display("mismatch at %0t got %h exp %h", $time, g, lo);
      end
   endtask
   // APB cycle; ready and data are looked at mid-cycle, settled before the edge that takes them
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_in) {psel, pwr, pa, pw} <= {1'b1, w, a, d};
      @(posedge clk_in) pen <= 1;
      n = 0;
      do begin
         @(negedge clk_in);
         n++;
      end while (rdy !== 1'b1 && n < 50);
      if (n >= 50) begin
         miscompares++;
         complete_run;
      end
      rd = prd;
      @(posedge clk_in) {psel, pen} <= 2'b00;
   endtask
   task rdw(input logic [11:0] a); apb(0, a, 0); endtask
   task wrw(input logic [11:0] a, input logic [31:0] d); apb(1, a, d); endtask
   task run_for(input int n);
      @(posedge clk_in) {halt, run} <= 2'b01;
      repeat (n) @(posedge clk_in);
      {halt, run} <= 2'b10;
   endtask
   //////////////////////////////
   initial begin
      repeat (6) @(posedge clk_in);
      rstn_in <= 1;
      rdw(12'h000); chk(rd, 32'hFF);
      rdw(12'h000); chk(rd, 32'hFF);
      rdw(12'h004); chk(rd, 32'hFC);
      wrw(12'h014, 1);
      // Every clock choice, then the external pin left unbonded
      for (int k = 0; k < 6; k++) begin
         @(posedge clk_in) bond <= (k < 5);
         wrw(12'h004, 0);
         wrw(12'h018, sel[k]);
         run_for(64);
         rdw(12'h008); v = rd;
         rdw(12'h00C);
         e = 16'hFFFC + 16'(dlt[k]);
         rng({16'h0, v[7:0], rd[7:0]}, e - (dlt[k] != 0), e + (dlt[k] != 0));
      end
      chk(irq, 0);
      @(posedge clk_in) mask <= 0;
      @(negedge clk_in) chk(irq, 1);
      rdw(12'h010); chk(rd, 32'h80);
      rdw(12'h00C); chk(irq, 1);
      rdw(12'h010); rdw(12'h004); chk(irq, 0);
      wrw(12'h018, 0); wrw(12'h004, 0); rdw(12'h000);
      run_for(40);
      rdw(12'h000); chk(rd, 0);
      rdw(12'h004); chk(rd, 32'hFC);
      rdw(12'h004); rng(rd, 5, 7);
      wrw(12'h004, 0); rdw(12'h004); chk(rd, 32'hFC);
      wrw(12'h00C, 0); rdw(12'h00C); chk(rd, 32'hFC);
      rdw(12'h01C); chk(rd, 0);
      complete_run;
   end
endmodule // tb_top
